//--- logic_shift_regs.svh
// Opcode, field and width constants for the logic and shift datapath.
// Assumes the 24-bit instruction word layout: a 12-bit opcode in the top
// bits, a 6-bit middle field and a 6-bit low field or shift count.
`ifndef LOGIC_SHIFT_REGS_SVH
`define LOGIC_SHIFT_REGS_SVH

// ============================================================
// Widths and field positions
`define WORD_W 24
`define SIGN_BIT 23
`define ARITH_S_W 23
`define ARITH_D_W 46
`define OPC_HI 23
`define OPC_LO 12
`define MEMOP_HI 23
`define MEMOP_LO 18
`define MID_HI 11
`define MID_LO 6
`define LOW_HI 5
`define LOW_LO 0
`define BYTE_HI 7
`define BYTE_LO 0
`define UPPER_LO 8
`define ROT_S_MOD 6'h18
`define ROT_D_MOD 6'h30

// ============================================================
// Opcodes
`define OPC_OR_PAIR 12'h018
`define OPC_XOR_PAIR 12'h017
`define OPC_XOR_BYTE 12'h00f
`define OPC_TRANSFER 12'h01e
`define MEMOP_XOR 6'h1f
`define OPC_ARITH_LEFT_SINGLE 12'h020
`define OPC_ARITH_RIGHT_SINGLE 12'h021
`define OPC_LOGIC_LEFT_SINGLE 12'h022
`define OPC_LOGIC_RIGHT_SINGLE 12'h023
`define OPC_ROTATE_LEFT_SINGLE 12'h024
`define OPC_ROTATE_RIGHT_SINGLE 12'h025
`define OPC_ARITH_LEFT_DOUBLE 12'h026
`define OPC_ARITH_RIGHT_DOUBLE 12'h027
`define OPC_LOGIC_LEFT_DOUBLE 12'h028
`define OPC_LOGIC_RIGHT_DOUBLE 12'h029
`define OPC_ROTATE_LEFT_DOUBLE 12'h02a
`define OPC_ROTATE_RIGHT_DOUBLE 12'h02b

// ============================================================
// One-hot register select codes
`define SEL_I 6'h01
`define SEL_J 6'h02
`define SEL_K 6'h04
`define SEL_E 6'h08
`define SEL_A 6'h10
`define SEL_T 6'h20

`endif

//--- logic_shift_pkg.sv
// Types shared by the logic and shift datapath and its shift unit.
// Assumes the constant header is on the include path.
`include "logic_shift_regs.svh"

package logic_shift_pkg;

    typedef logic [`WORD_W-1:0] word_type;

    typedef struct packed {
        word_type i;
        word_type j;
        word_type k;
        word_type e;
        word_type a;
        word_type t;
    } gen_regs_type;

    typedef struct packed {
        logic overflow;
        logic positive;
        logic negative;
        logic zero;
    } cond_type;

    typedef enum logic [12:0] {
        shift_idle           = 13'h0001,
        arith_left_single    = 13'h0002,
        arith_right_single   = 13'h0004,
        logic_left_single    = 13'h0008,
        logic_right_single   = 13'h0010,
        rotate_left_single   = 13'h0020,
        rotate_right_single  = 13'h0040,
        arith_left_double    = 13'h0080,
        arith_right_double   = 13'h0100,
        logic_left_double    = 13'h0200,
        logic_right_double   = 13'h0400,
        rotate_left_double   = 13'h0800,
        rotate_right_double  = 13'h1000
    } shift_kind_type;

endpackage : logic_shift_pkg

//--- shift_unit.sv
// Combinational shifter for the single (A) and double (E,A) registers.
// Assumes the caller registers the result; count is 0 to 63.
`include "logic_shift_regs.svh"

module shift_unit
    import logic_shift_pkg::*;
(
    // Operands
    input wire word_type e_in,
    input wire word_type a_in,
    input wire logic [5:0] count,
    input wire shift_kind_type kind,
    // Results
    output word_type e_out,
    output word_type a_out,
    output logic overflow
);

    // ============================================================
    // Overflow of an arithmetic left shift
    // Zeros that follow the payload off the top also count against a
    // negative sign, so counts above the payload width still flag.
    function automatic logic left_overflow(input logic [45:0] pay, input logic sign,
                                           input logic [5:0] n, input logic dbl);
        int w;
        logic hit;
        w = dbl ? `ARITH_D_W : `ARITH_S_W;
        hit = (int'(n) > w) && sign;
        for (int i = 0; i < `ARITH_D_W; i++) begin
            if (i < w && i + int'(n) >= w && pay[i] != sign) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : left_overflow

    // ============================================================
    // Single register forms
    wire [5:0] rot_s = count % `ROT_S_MOD;
    wire [5:0] rot_d = count % `ROT_D_MOD;
    wire word_type lsl_s = a_in << count;
    wire word_type lsr_s = a_in >> count;
    wire [`ARITH_S_W-1:0] asl_pay = a_in[`SIGN_BIT-1:0] << count;
    wire word_type asl_s = {a_in[`SIGN_BIT], asl_pay};
    wire word_type asr_s = $signed(a_in) >>> count;
    wire [47:0] rol_s_wide = {a_in, a_in} << rot_s;
    wire [47:0] ror_s_wide = {a_in, a_in} >> rot_s;

    // ============================================================
    // Double register forms
    wire [47:0] dbl_in = {e_in, a_in};
    wire [45:0] pay_d = {e_in[`SIGN_BIT-1:0], a_in[`SIGN_BIT-1:0]};
    wire [45:0] asl_d = pay_d << count;
    wire signed [46:0] signed_d = {e_in[`SIGN_BIT], pay_d};
    wire [46:0] asr_d = signed_d >>> count;
    wire [47:0] lsl_d = dbl_in << count;
    wire [47:0] lsr_d = dbl_in >> count;
    wire [95:0] rol_d_wide = {dbl_in, dbl_in} << rot_d;
    wire [95:0] ror_d_wide = {dbl_in, dbl_in} >> rot_d;

    always_comb begin
        e_out = e_in;
        a_out = a_in;
        overflow = 1'b0;
        unique case (kind)
            shift_idle: begin
            end
            arith_left_single: begin
                a_out = asl_s;
                overflow = left_overflow({23'h0, a_in[`SIGN_BIT-1:0]}, a_in[`SIGN_BIT],
                                         count, 1'b0);
            end
            arith_right_single: a_out = asr_s;
            logic_left_single: a_out = lsl_s;
            logic_right_single: a_out = lsr_s;
            rotate_left_single: a_out = rol_s_wide[47:24];
            rotate_right_single: a_out = ror_s_wide[23:0];
            arith_left_double: begin
                e_out = {e_in[`SIGN_BIT], asl_d[45:23]};
                a_out = {a_in[`SIGN_BIT], asl_d[22:0]};
                overflow = left_overflow(pay_d, e_in[`SIGN_BIT], count, 1'b1);
            end
            arith_right_double: begin
                e_out = asr_d[46:23];
                a_out = {a_in[`SIGN_BIT], asr_d[22:0]};
            end
            logic_left_double: {e_out, a_out} = lsl_d;
            logic_right_double: {e_out, a_out} = lsr_d;
            rotate_left_double: {e_out, a_out} = rol_d_wide[95:48];
            rotate_right_double: {e_out, a_out} = ror_d_wide[47:0];
        endcase
    end

endmodule : shift_unit

//--- logic_shift_datapath.sv
// Execution datapath for the OR, exclusive-OR, shift and register
// transfer groups of a 24-bit CPU, with its general registers and the
// condition register. Assumes the fetch logic presents one decoded
// instruction word per issue pulse and the memory word alongside it.
`include "logic_shift_regs.svh"

// Behaviour
// - OR pair opcode, combined middle field, destination last.
// - One-hot select codes name I,J,K,E,A,T.
// - Memory opcode XORs memory word into A.
// - Byte XOR touches only A bits 0-7.
// - XOR pair changes only destination and condition.
// - Shift count from bits 0-5, 1-63; count 0 is also accepted and leaves E and A unchanged.
// - Condition reflects shifted register after every shift.
// - Arithmetic left single keeps A sign bit.
// - Bit leaving A22 unlike sign sets overflow.
// - Arithmetic left double skips signs, flags E22 overflow.
// - Logical left single shifts all 24 bits.
// - Logical left double shifts all 48 bits.
// - Left rotate single loses no bit.
// - Left rotate double: E23 to A0, A23 to E0.
// - Arithmetic right single sign-extends, keeps sign.
// - Arithmetic right double extends E23, skips A23.
// - Logical right single fills top with zeros.
// - Logical right double fills top with zeros.
// - Right rotate single loses no bit.
// - Right rotate double: E0 to A23, A0 to E23.
// - Transfer sets condition from new destination.
// - Transfer leaves the source untouched.
// - Logic result replaces second operand, first kept.
module logic_shift_datapath
    import logic_shift_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Instruction issue
    input wire logic issue_valid,
    input wire word_type instr_word,
    input wire word_type mem_word,
    // Register load from the surrounding CPU
    input wire logic load_valid,
    input wire logic [5:0] load_sel,
    input wire word_type load_data,
    // State and completion
    output gen_regs_type regs,
    output cond_type cond,
    output logic done,
    output logic refused
);

    // ============================================================
    // Register file helpers
    function automatic logic valid_code(input logic [5:0] code);
        return code == `SEL_I || code == `SEL_J || code == `SEL_K ||
               code == `SEL_E || code == `SEL_A || code == `SEL_T;
    endfunction : valid_code

    function automatic word_type read_reg(input gen_regs_type r, input logic [5:0] code);
        word_type v;
        v = '0;
        case (code)
            `SEL_I: v = r.i;
            `SEL_J: v = r.j;
            `SEL_K: v = r.k;
            `SEL_E: v = r.e;
            `SEL_A: v = r.a;
            `SEL_T: v = r.t;
            default: v = '0;
        endcase
        return v;
    endfunction : read_reg

    function automatic gen_regs_type write_reg(input gen_regs_type r, input logic [5:0] code,
                                               input word_type v);
        gen_regs_type n;
        n = r;
        case (code)
            `SEL_I: n.i = v;
            `SEL_J: n.j = v;
            `SEL_K: n.k = v;
            `SEL_E: n.e = v;
            `SEL_A: n.a = v;
            `SEL_T: n.t = v;
            default: n = r;
        endcase
        return n;
    endfunction : write_reg

    // A double result is judged as one 48-bit value signed by E23.
    function automatic cond_type cond_of(input logic [47:0] v, input logic dbl,
                                         input logic ovf);
        cond_type c;
        c.overflow = ovf;
        c.negative = dbl ? v[47] : v[`SIGN_BIT];
        c.zero = dbl ? (v == '0) : (v[`WORD_W-1:0] == '0);
        c.positive = !c.negative && !c.zero;
        return c;
    endfunction : cond_of

    function automatic shift_kind_type kind_of(input logic [11:0] opc);
        shift_kind_type k;
        k = shift_idle;
        case (opc)
            `OPC_ARITH_LEFT_SINGLE: k = arith_left_single;
            `OPC_ARITH_RIGHT_SINGLE: k = arith_right_single;
            `OPC_LOGIC_LEFT_SINGLE: k = logic_left_single;
            `OPC_LOGIC_RIGHT_SINGLE: k = logic_right_single;
            `OPC_ROTATE_LEFT_SINGLE: k = rotate_left_single;
            `OPC_ROTATE_RIGHT_SINGLE: k = rotate_right_single;
            `OPC_ARITH_LEFT_DOUBLE: k = arith_left_double;
            `OPC_ARITH_RIGHT_DOUBLE: k = arith_right_double;
            `OPC_LOGIC_LEFT_DOUBLE: k = logic_left_double;
            `OPC_LOGIC_RIGHT_DOUBLE: k = logic_right_double;
            `OPC_ROTATE_LEFT_DOUBLE: k = rotate_left_double;
            `OPC_ROTATE_RIGHT_DOUBLE: k = rotate_right_double;
            default: k = shift_idle;
        endcase
        return k;
    endfunction : kind_of

    // ============================================================
    // State
    gen_regs_type regs_ff;
    gen_regs_type nxt_regs;
    cond_type cond_ff;
    cond_type nxt_cond;
    logic done_ff;
    logic nxt_done;
    logic refused_ff;
    logic nxt_refused;

    // ============================================================
    // Decode
    wire [11:0] opc = instr_word[`OPC_HI:`OPC_LO];
    wire [5:0] mid = instr_word[`MID_HI:`MID_LO];
    wire [5:0] low = instr_word[`LOW_HI:`LOW_LO];
    wire [5:0] count = instr_word[`LOW_HI:`LOW_LO];
    wire is_or = opc == `OPC_OR_PAIR;
    wire is_xor = opc == `OPC_XOR_PAIR;
    wire is_xfer = opc == `OPC_TRANSFER;
    wire is_xor_byte = opc == `OPC_XOR_BYTE;
    wire is_xor_mem = instr_word[`MEMOP_HI:`MEMOP_LO] == `MEMOP_XOR;
    wire shift_kind_type kind = kind_of(opc);
    wire is_shift = kind != shift_idle;
    wire is_double = kind inside {arith_left_double, arith_right_double, logic_left_double,
                                  logic_right_double, rotate_left_double, rotate_right_double};

    // The OR group folds the destination code into the middle field, so the
    // source is what remains once the destination bit is removed.
    wire [5:0] src_code = is_or ? (mid & ~low) : mid;
    wire [5:0] dst_code = low;
    wire pair_ok = valid_code(src_code) && valid_code(dst_code) && src_code != dst_code &&
                   (!is_or || (mid & low) == low);
    wire is_pair = is_or || is_xor || is_xfer;
    wire do_pair = issue_valid && is_pair && pair_ok;
    wire word_type src_val = read_reg(regs_ff, src_code);
    wire word_type dst_val = read_reg(regs_ff, dst_code);
    wire word_type pair_res = is_or ? (src_val | dst_val) :
                              is_xor ? (src_val ^ dst_val) :
                              src_val;
    wire word_type xor_mem_res = regs_ff.a ^ mem_word;
    wire word_type xor_byte_res = {regs_ff.a[`WORD_W-1:`UPPER_LO],
                                   regs_ff.a[`BYTE_HI:`BYTE_LO] ^
                                   instr_word[`BYTE_HI:`BYTE_LO]};
    wire known = is_pair || is_xor_mem || is_xor_byte || is_shift;

    // ============================================================
    // Shift unit
    word_type sh_e;
    word_type sh_a;
    logic sh_ovf;

    shift_unit u_shift (
        .e_in(regs_ff.e),
        .a_in(regs_ff.a),
        .count(count),
        .kind(kind),
        .e_out(sh_e),
        .a_out(sh_a),
        .overflow(sh_ovf)
    );

    // ============================================================
    // Next state
    // An instruction and a load in the same cycle would race on the same
    // registers, so the instruction wins and the load is dropped.
    always_comb begin
        nxt_regs = regs_ff;
        nxt_cond = cond_ff;
        nxt_done = 1'b0;
        nxt_refused = 1'b0;
        if (issue_valid) begin
            if (!known || (is_pair && !pair_ok)) begin
                nxt_refused = 1'b1;
            end else if (is_pair) begin
                nxt_regs = write_reg(regs_ff, dst_code, pair_res);
                nxt_cond = cond_of({24'h0, pair_res}, 1'b0, 1'b0);
                nxt_done = 1'b1;
            end else if (is_xor_mem) begin
                nxt_regs.a = xor_mem_res;
                nxt_cond = cond_of({24'h0, xor_mem_res}, 1'b0, 1'b0);
                nxt_done = 1'b1;
            end else if (is_xor_byte) begin
                nxt_regs.a = xor_byte_res;
                nxt_cond = cond_of({24'h0, xor_byte_res}, 1'b0, 1'b0);
                nxt_done = 1'b1;
            end else begin
                nxt_regs.a = sh_a;
                nxt_regs.e = is_double ? sh_e : regs_ff.e;
                nxt_cond = is_double ? cond_of({sh_e, sh_a}, 1'b1, sh_ovf) :
                                       cond_of({24'h0, sh_a}, 1'b0, sh_ovf);
                nxt_done = 1'b1;
            end
        end else if (load_valid) begin
            nxt_regs = write_reg(regs_ff, load_sel, load_data);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            regs_ff <= '0;
            cond_ff <= '0;
            done_ff <= 1'b0;
            refused_ff <= 1'b0;
        end else begin
            regs_ff <= nxt_regs;
            cond_ff <= nxt_cond;
            done_ff <= nxt_done;
            refused_ff <= nxt_refused;
        end
    end

    assign regs = regs_ff;
    assign cond = cond_ff;
    assign done = done_ff;
    assign refused = refused_ff;

    // ============================================================
    // Checks
    default clocking chk_clk @(posedge clock); endclocking
    default disable iff (srst);

    chk_or_result: assert property (
        issue_valid && is_or && pair_ok |=>
            read_reg(regs_ff, $past(dst_code)) == ($past(src_val) | $past(dst_val)) && done_ff)
        else $error("OR pair result wrong");

    chk_xor_result: assert property (
        issue_valid && is_xor && pair_ok |=>
            read_reg(regs_ff, $past(dst_code)) == ($past(src_val) ^ $past(dst_val)))
        else $error("XOR pair result wrong");

    chk_pair_source_kept: assert property (
        do_pair |=> read_reg(regs_ff, $past(src_code)) == $past(src_val))
        else $error("pair source register changed");

    chk_xor_memory: assert property (
        issue_valid && !is_pair && is_xor_mem |=>
            regs_ff.a == ($past(regs_ff.a) ^ $past(mem_word)) && regs_ff.e == $past(regs_ff.e))
        else $error("memory XOR into accumulator wrong");

    chk_byte_upper_kept: assert property (
        issue_valid && is_xor_byte |=>
            regs_ff.a[`WORD_W-1:`UPPER_LO] == $past(regs_ff.a[`WORD_W-1:`UPPER_LO]) &&
            regs_ff.a[`BYTE_HI:`BYTE_LO] ==
            ($past(regs_ff.a[`BYTE_HI:`BYTE_LO]) ^ $past(instr_word[`BYTE_HI:`BYTE_LO])))
        else $error("byte XOR touched upper bits or wrong");

    chk_arith_sign_kept: assert property (
        issue_valid && kind == arith_left_single |=>
            regs_ff.a[`SIGN_BIT] == $past(regs_ff.a[`SIGN_BIT]) && regs_ff.e == $past(regs_ff.e))
        else $error("arithmetic left shift changed sign");

    chk_one_step_overflow: assert property (
        issue_valid && kind == arith_left_single && count == 6'h01 &&
        regs_ff.a[`SIGN_BIT-1] != regs_ff.a[`SIGN_BIT] |=> cond_ff.overflow)
        else $error("overflow missed on arithmetic left shift");

    chk_rotate_single_lossless: assert property (
        issue_valid && (kind == rotate_left_single || kind == rotate_right_single) |=>
            $countones(regs_ff.a) == $countones($past(regs_ff.a)))
        else $error("single rotate lost a bit");

    chk_rotate_double_lossless: assert property (
        issue_valid && (kind == rotate_left_double || kind == rotate_right_double) |=>
            $countones({regs_ff.e, regs_ff.a}) == $countones({$past(regs_ff.e), $past(regs_ff.a)}))
        else $error("double rotate lost a bit");

    chk_single_shift_cond: assert property (
        issue_valid && is_shift && !is_double |=>
            cond_ff.negative == regs_ff.a[`SIGN_BIT] && cond_ff.zero == (regs_ff.a == '0))
        else $error("condition does not track shifted accumulator");

    chk_transfer_cond: assert property (
        issue_valid && is_xfer && pair_ok |=>
            cond_ff.zero == ($past(src_val) == '0) &&
            cond_ff.negative == $past(src_val[`SIGN_BIT]))
        else $error("transfer condition wrong");

    chk_refused_pair: assert property (
        issue_valid && is_pair && !pair_ok |=> refused_ff && regs_ff == $past(regs_ff))
        else $error("select codes not refused");

    chk_xor_dest_only: assert property (
        do_pair && is_xor |=> regs_ff == write_reg($past(regs_ff), $past(dst_code),
            read_reg(regs_ff, $past(dst_code))))
        else $error("XOR pair touched other register");

    chk_pair_cond: assert property (
        do_pair |=> !cond_ff.overflow &&
            cond_ff.zero == (read_reg(regs_ff, $past(dst_code)) == '0))
        else $error("pair condition wrong");

    chk_accum_xor_cond: assert property (
        issue_valid && !is_pair && (is_xor_mem || is_xor_byte) |=>
            cond_ff.zero == (regs_ff.a == '0) && cond_ff.negative == regs_ff.a[`SIGN_BIT])
        else $error("accumulator XOR condition wrong");

    chk_logic_left_step: assert property (
        issue_valid && kind == logic_left_single && count == 6'h01 |=>
            regs_ff.a == {$past(regs_ff.a[`SIGN_BIT-1:0]), 1'b0})
        else $error("logical left shift wrong");

    chk_arith_right_step: assert property (
        issue_valid && kind == arith_right_single && count == 6'h01 |=>
            regs_ff.a == {$past(regs_ff.a[`SIGN_BIT]), $past(regs_ff.a[`SIGN_BIT:1])})
        else $error("arithmetic right shift wrong");

    chk_double_left_step: assert property (
        issue_valid && kind == logic_left_double && count == 6'h01 |=>
            {regs_ff.e, regs_ff.a} == {$past(regs_ff.e[`SIGN_BIT-1:0]), $past(regs_ff.a), 1'b0})
        else $error("double logical left shift wrong");

    chk_double_rotate_ends: assert property (
        issue_valid && kind == rotate_left_double && count == 6'h01 |=>
            regs_ff.a[0] == $past(regs_ff.e[`SIGN_BIT]) &&
            regs_ff.e[0] == $past(regs_ff.a[`SIGN_BIT]))
        else $error("double left rotate wrong");

    chk_double_shift_cond: assert property (
        issue_valid && is_double |=> cond_ff.negative == regs_ff.e[`SIGN_BIT] &&
            cond_ff.zero == ({regs_ff.e, regs_ff.a} == '0))
        else $error("double condition wrong");

endmodule : logic_shift_datapath

//--- tb.sv
// Self-checking bench for the logic and shift datapath.
// Drives every datapath port directly; expectations come from a bench model.
`include "logic_shift_regs.svh"

module tb
    import logic_shift_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ====================
    // Stimulus and model state
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic issue_valid = 1'b0;
    logic load_valid = 1'b0;
    word_type instr_word = '0;
    word_type mem_word = '0;
    word_type load_data = '0;
    logic [5:0] load_sel = '0;
    gen_regs_type regs;
    cond_type cond;
    logic done;
    logic refused;
    gen_regs_type m_regs;
    cond_type m_cond;
    int n_fail = 0;
    int n_compared = 0;
    logic [31:0] rnd = 32'hd24d95cf;
    logic [5:0] sels [6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20};

    always #2.5 clock = ~clock;

    logic_shift_datapath u_dut (.clock(clock), .srst(srst), .issue_valid(issue_valid),
        .instr_word(instr_word), .mem_word(mem_word), .load_valid(load_valid),
        .load_sel(load_sel), .load_data(load_data), .regs(regs), .cond(cond),
        .done(done), .refused(refused));

    // ====================
    // Model functions
    function automatic word_type rnd_word();
        rnd = {rnd[30:0], 1'b0} ^ (rnd[31] ? 32'h04c11db7 : 32'h00000000);
        return rnd[31:8];
    endfunction : rnd_word

    function automatic cond_type cc(input word_type v);
        return {1'b0, ~v[23] & (|v), v[23], ~|v};
    endfunction : cc

    function automatic word_type rd(input gen_regs_type r, input logic [5:0] s);
        case (s)
            6'h01: return r.i;
            6'h02: return r.j;
            6'h04: return r.k;
            6'h08: return r.e;
            6'h10: return r.a;
            default: return r.t;
        endcase
    endfunction : rd

    function automatic gen_regs_type wr(input gen_regs_type r, input logic [5:0] s,
                                        input word_type v);
        case (s)
            6'h01: r.i = v;
            6'h02: r.j = v;
            6'h04: r.k = v;
            6'h08: r.e = v;
            6'h10: r.a = v;
            6'h20: r.t = v;
            default: ;
        endcase
        return r;
    endfunction : wr

    // One step at a time, so rotations and overflow need no modulo tricks.
    function automatic logic [48:0] shf(input logic [11:0] opc, input logic [47:0] d,
                                        input logic [5:0] n);
        logic ovf;
        ovf = 1'b0;
        for (int i = 0; i < n; i++) begin
            case (opc)
                12'h020: begin
                    ovf |= d[22] ^ d[23];
                    d[23:0] = {d[23], d[21:0], 1'b0};
                end
                12'h021: d[23:0] = {d[23], d[23], d[22:1]};
                12'h022: d[23:0] = d[23:0] << 1;
                12'h023: d[23:0] = d[23:0] >> 1;
                12'h024: d[23:0] = {d[22:0], d[23]};
                12'h025: d[23:0] = {d[0], d[23:1]};
                12'h026: begin
                    ovf |= d[46] ^ d[47];
                    d = {d[47], d[45:24], d[22], d[23], d[21:0], 1'b0};
                end
                12'h027: d = {d[47], d[47], d[46:25], d[23], d[24], d[22:1]};
                12'h028: d = d << 1;
                12'h029: d = d >> 1;
                12'h02a: d = {d[46:0], d[47]};
                default: d = {d[0], d[47:1]};
            endcase
        end
        return {ovf, d};
    endfunction : shf

    // ====================
    // Drivers and checks
    task automatic check(input string name, input logic [143:0] exp, input logic [143:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    task automatic load(input logic [5:0] s, input word_type v);
        @(posedge clock);
        #1 load_valid = 1'b1;
        load_sel = s;
        load_data = v;
        @(posedge clock);
        #1 load_valid = 1'b0;
        m_regs = wr(m_regs, s, v);
    endtask : load

    // The model is updated by the caller before the instruction is issued.
    task automatic exec(input word_type iw, input word_type mw, input logic ok);
        @(posedge clock);
        #1 issue_valid = 1'b1;
        instr_word = iw;
        mem_word = mw;
        @(posedge clock);
        #1 issue_valid = 1'b0;
        check("done refused", 144'({ok, ~ok}), 144'({done, refused}));
        check("regs", m_regs, regs);
        check("cond", 144'(m_cond), 144'(cond));
    endtask : exec

    initial begin
        #100000;
        n_fail++;
        final_report();
    end

    initial begin
        word_type sv;
        word_type r;
        word_type iw;
        logic [48:0] res;
        logic [5:0] cnts [8];
        m_regs = '0;
        m_cond = '0;
        repeat (3) @(posedge clock);
        #1 srst = 1'b0;
        check("reset regs", m_regs, regs);
        load(6'h03, 24'h123456);
        check("bad load", m_regs, regs);
        for (int g = 0; g < 3; g++) begin
            for (int i = 0; i < 6; i++) load(sels[i], rnd_word());
            for (int s = 0; s < 6; s++) begin
                for (int d = 0; d < 6; d++) begin
                    if (s != d) begin
                        sv = rd(m_regs, sels[s]);
                        r = (g == 0) ? (sv | rd(m_regs, sels[d])) :
                            (g == 1) ? (sv ^ rd(m_regs, sels[d])) : sv;
                        iw = (g == 0) ? {`OPC_OR_PAIR, sels[s] | sels[d], sels[d]} :
                             (g == 1) ? {`OPC_XOR_PAIR, sels[s], sels[d]} :
                             {`OPC_TRANSFER, sels[s], sels[d]};
                        m_regs = wr(m_regs, sels[d], r);
                        m_cond = cc(r);
                        exec(iw, rnd_word(), 1'b1);
                    end
                end
            end
        end
        for (int i = 0; i < 8; i++) begin
            r = rnd_word();
            m_regs.a[7:0] = m_regs.a[7:0] ^ r[7:0];
            m_cond = cc(m_regs.a);
            exec({`OPC_XOR_BYTE, 4'h0, r[7:0]}, rnd_word(), 1'b1);
            sv = rnd_word();
            m_regs.a = m_regs.a ^ sv;
            m_cond = cc(m_regs.a);
            exec({`MEMOP_XOR, r[17:0]}, sv, 1'b1);
        end
        exec({`OPC_OR_PAIR, `SEL_J, `SEL_J}, 24'h000000, 1'b0);
        exec({12'h0ff, 12'h000}, 24'h000000, 1'b0);
        cnts = '{6'h01, 6'h16, 6'h17, 6'h18, 6'h2e, 6'h2f, 6'h3f, 6'h00};
        for (int v = 0; v < 4; v++) begin
            for (int k = 0; k < 12; k++) begin
                for (int c = 0; c < 8; c++) begin
                    if (c == 7) cnts[7] = 6'(rnd_word() % 24'h00003f + 24'h000001);
                    load(`SEL_E, v == 0 ? 24'h400000 : v == 1 ? 24'h800000 : rnd_word());
                    load(`SEL_A, v == 0 ? 24'h400001 : v == 1 ? 24'h000000 : rnd_word());
                    res = shf(12'h020 + 12'(k), {m_regs.e, m_regs.a}, cnts[c]);
                    m_regs.e = res[47:24];
                    m_regs.a = res[23:0];
                    m_cond = (k < 6) ? cc(res[23:0]) :
                        {1'b0, ~res[47] & (|res[47:0]), res[47], ~|res[47:0]};
                    m_cond.overflow = res[48];
                    exec({12'h020 + 12'(k), 6'h00, cnts[c]}, rnd_word(), 1'b1);
                end
            end
        end
        final_report();
    end
endmodule : tb
